// [rtl/ltg_top.sv]
/*
 lfsr traffic generator and checker around a serial link core, plus a shift fifo.
 assumes: core streams and the ahb-lite master run on CLK; INIT_CLK is free running.
*/
// Notes on behaviour
// - generator drives data, user flow, native flow control and control-block streams
// - payload comes from an lfsr loaded with a fixed seed after reset
// - generator runs on CLK; steered by reset, channel up and the pause control bit
// - valid/ready handshake; next word only after the current one is taken
// - checker lfsr uses the same polynomial and seed as the generator
// - every valid word received while channel up is compared; mismatches reported
// - checking applies to all four receive streams separately
// - eight-bit count of mismatching main data words
// - user flow message mismatch raises an active-high flag
// - control-block mismatch raises an active-high flag
// - hard and soft error inputs are registered before output
// - channel up is registered before output
// - one registered lane-up output per lane
// - transceiver reset input registered and debounced on the housekeeping clock
// - transmit-only drops the checker, receive-only drops the generator
// - reset returns lfsrs, flags and counter to their start values
`include "ltg_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
module ltg_fifo
   import ltg_pkg::*;
#(
   parameter int W = `LTG_DW,
   parameter int DEPTH = `LTG_FIFO_DEPTH
)
(
   input logic clk,
   input logic nrst,
   input logic en,
   input logic clr,
   input logic in_valid,
   input logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input logic out_ready
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic vld_q;
   logic push;
   logic pop;
   logic [W-1:0] head;

   // head sits in entry 0 so the output is a flop, not a read mux
   assign in_ready = (cnt_q != CW'(DEPTH));
   assign push = in_valid && in_ready;
   assign pop = vld_q && out_ready;
   assign out_valid = vld_q;
   assign out_data = head;

   // occupancy; a clear drops everything, used when the link goes down
   always_comb
   begin
      cnt_d = cnt_q;
      if (clr)
         cnt_d = '0;
      else if (push && !pop)
         cnt_d = cnt_q + CW'(1);
      else if (pop && !push)
         cnt_d = cnt_q - CW'(1);
   end

   always_ff @(posedge clk)
      if (!nrst)
      begin
         cnt_q <= '0;
         vld_q <= 1'b0;
      end
      else if (en)
      begin
         cnt_q <= cnt_d;
         vld_q <= (cnt_d != '0);
      end

   // per entry: shift down on pop, load the incoming word at the tail
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_ent
      logic [W-1:0] q;
      logic [W-1:0] up;
      if (i == DEPTH - 1)
      begin : g_last
         assign up = '0;
      end
      else
      begin : g_mid
         assign up = g_ent[i + 1].q;
      end
      always_ff @(posedge clk)
         if (en)
         begin
            if (pop && push && cnt_q == CW'(i + 1))
               q <= in_data;
            else if (pop)
               q <= up;
            else if (push && cnt_q == CW'(i))
               q <= in_data;
         end
   end
   assign head = g_ent[0].q;
endmodule

////////////////////////////////////////////////////////////////////////////////
module ltg_top
   import ltg_pkg::*;
#(
   parameter int NL = 1,
   parameter bit HAS_TX = 1'b1,
   parameter bit HAS_RX = 1'b1,
   parameter int FIFO_DEPTH = `LTG_FIFO_DEPTH,
   parameter int DEB_LEN = `LTG_DEB_LEN
)
(
   input logic CLK,
   input logic NRST,
   input logic CE,
   input logic INIT_CLK,
   input logic PMA_INIT_IN,
   output logic PMA_INIT_OUT,
   input logic CORE_CHANNEL_UP,
   input logic [NL-1:0] CORE_LANE_UP,
   input logic CORE_HARD_ERR,
   input logic CORE_SOFT_ERR,
   output ltg_beat_t [`LTG_NIF-1:0] TX_BEAT,
   input logic [`LTG_NIF-1:0] TX_READY,
   input ltg_beat_t [`LTG_NIF-1:0] RX_BEAT,
   output logic CHANNEL_UP,
   output logic [NL-1:0] LANE_UP,
   output logic HARD_ERR,
   output logic SOFT_ERR,
   output logic [`LTG_CNT_W-1:0] MISMATCH_WORD_COUNT,
   output logic [`LTG_NIF-1:0] RX_ERR,
   input logic HSEL,
   input logic [31:0] HADDR,
   input logic [1:0] HTRANS,
   input logic HWRITE,
   input logic [2:0] HSIZE,
   input logic [31:0] HWDATA,
   input logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   localparam int NIF = `LTG_NIF;
   logic pause_q;
   logic clr_q;
   logic [`LTG_CNT_W-1:0] cnt_q;
   logic [NIF-1:0] bad;
   logic [NIF-1:0] err_q;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   ////////////////////////////////////////////////////////////////////////////
   // link status, registered in the user clock domain
   always_ff @(posedge CLK)
      if (!NRST)
      begin
         CHANNEL_UP <= 1'b0;
         LANE_UP <= '0;
         HARD_ERR <= 1'b0;
         SOFT_ERR <= 1'b0;
      end
      else if (CE)
      begin
         CHANNEL_UP <= CORE_CHANNEL_UP;
         LANE_UP <= CORE_LANE_UP;
         HARD_ERR <= CORE_HARD_ERR;
         SOFT_ERR <= CORE_SOFT_ERR;
      end

   a_stat_chan: assert property (CE |=> CHANNEL_UP == $past(CORE_CHANNEL_UP))
      else $error("channel up not registered");
   a_stat_errs: assert property (CE |=> HARD_ERR == $past(CORE_HARD_ERR) && SOFT_ERR == $past(CORE_SOFT_ERR))
      else $error("error inputs not registered");

   ////////////////////////////////////////////////////////////////////////////
   // generator: one lfsr per transmit stream; data stream goes through the fifo
   if (HAS_TX)
   begin : g_tx
      for (genvar i = 0; i < NIF; i++)
      begin : g_if
         logic [`LTG_LW-1:0] lfsr_q;
         logic vld_q;
         logic rdy;
         // reset and channel up restart it at the seed; pause merely withholds new words
         always_ff @(posedge CLK)
            if (!NRST)
            begin
               lfsr_q <= `LTG_LFSR_SEED;
               vld_q <= 1'b0;
            end
            else if (CE)
            begin
               if (!CORE_CHANNEL_UP)
               begin
                  lfsr_q <= `LTG_LFSR_SEED;
                  vld_q <= 1'b0;
               end
               else
               begin
                  if (vld_q && rdy)
                     lfsr_q <= ltg_lfsr_next(lfsr_q);
                  if (!vld_q || rdy)
                     vld_q <= !pause_q;
               end
            end

         if (i == `LTG_IF_DATA)
         begin : g_buf
            logic fvld;
            logic [`LTG_DW-1:0] fdat;
            // core back-pressure fills the fifo, then stalls the lfsr
            ltg_fifo #(.W(`LTG_DW), .DEPTH(FIFO_DEPTH)) u_fifo
            (
               .clk(CLK),
               .nrst(NRST),
               .en(CE),
               .clr(!CORE_CHANNEL_UP),
               .in_valid(vld_q),
               .in_data(ltg_word(lfsr_q)),
               .in_ready(rdy),
               .out_valid(fvld),
               .out_data(fdat),
               .out_ready(TX_READY[i])
            );
            assign TX_BEAT[i] = '{valid: fvld, data: fdat};
         end
         else
         begin : g_dir
            assign rdy = TX_READY[i];
            assign TX_BEAT[i] = '{valid: vld_q, data: ltg_word(lfsr_q)};
         end

         a_gen_seed: assert property ($rose(NRST) |-> lfsr_q == `LTG_LFSR_SEED)
            else $error("generator lfsr not at seed after reset");
         a_gen_down: assert property (CE && !CORE_CHANNEL_UP |=> !TX_BEAT[i].valid)
            else $error("valid while channel down");
         a_gen_hold: assert property (CE && CORE_CHANNEL_UP && TX_BEAT[i].valid && !TX_READY[i]
            ##1 CORE_CHANNEL_UP |-> TX_BEAT[i].valid && $stable(TX_BEAT[i].data))
            else $error("beat changed before acceptance");
      end
   end
   else
   begin : g_no_tx
      assign TX_BEAT = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checker: same lfsr per receive stream, compared on valid beats only
   if (HAS_RX)
   begin : g_rx
      for (genvar i = 0; i < NIF; i++)
      begin : g_if
         logic [`LTG_LW-1:0] exp_q;
         logic beat;
         assign beat = RX_BEAT[i].valid && CORE_CHANNEL_UP;
         assign bad[i] = beat && RX_BEAT[i].data != ltg_word(exp_q);
         always_ff @(posedge CLK)
            if (!NRST)
            begin
               exp_q <= `LTG_LFSR_SEED;
               err_q[i] <= 1'b0;
            end
            else if (CE)
            begin
               if (!CORE_CHANNEL_UP)
                  exp_q <= `LTG_LFSR_SEED;
               else if (beat)
                  exp_q <= ltg_lfsr_next(exp_q);
               err_q[i] <= bad[i];
            end

         a_chk_flag: assert property (CE && bad[i] |=> RX_ERR[i])
            else $error("mismatch not flagged");
         a_chk_idle: assert property (CE && !CORE_CHANNEL_UP |=> !RX_ERR[i] && exp_q == `LTG_LFSR_SEED)
            else $error("beat checked while channel down");
      end
   end
   else
   begin : g_no_rx
      assign bad = '0;
      assign err_q = '0;
   end
   assign RX_ERR = err_q;

   // mismatch counter; an error in the clear cycle still counts
   always_ff @(posedge CLK)
      if (!NRST)
         cnt_q <= '0;
      else if (CE)
      begin
         if (clr_q)
            cnt_q <= bad[`LTG_IF_DATA] ? `LTG_CNT_ONE : '0;
         else if (bad[`LTG_IF_DATA] && cnt_q != `LTG_CNT_MAX)
            cnt_q <= cnt_q + `LTG_CNT_ONE;
      end
   assign MISMATCH_WORD_COUNT = cnt_q;

   a_cnt_step: assert property (CE && bad[`LTG_IF_DATA] && !clr_q && cnt_q != `LTG_CNT_MAX
      |=> cnt_q == $past(cnt_q) + `LTG_CNT_ONE)
      else $error("counter did not step on mismatch");
   a_cnt_sat: assert property (CE && cnt_q == `LTG_CNT_MAX && !clr_q |=> cnt_q == `LTG_CNT_MAX)
      else $error("counter wrapped");

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait state, always okay
   logic wr_q;
   logic [31:0] waddr_q;
   logic acc;
   logic [31:0] rmux;
   assign acc = HSEL && HTRANS[1] && HREADY;
   assign HRESP = 1'b0;

   // read data is captured in the address phase and shown in the data phase
   always_comb
   begin
      rmux = 32'h0000_0000;
      if (HADDR == `LTG_OFF_CTRL)
         rmux[`LTG_CTRL_PAUSE] = pause_q;
      else if (HADDR == `LTG_OFF_STAT)
      begin
         rmux[`LTG_CNT_W-1:0] = cnt_q;
         rmux[`LTG_STAT_CHAN] = CHANNEL_UP;
         rmux[`LTG_STAT_HARD] = HARD_ERR;
         rmux[`LTG_STAT_SOFT] = SOFT_ERR;
         rmux[`LTG_STAT_ERR +: NIF] = err_q;
         rmux[`LTG_STAT_LANE +: NL] = LANE_UP;
      end
   end

   always_ff @(posedge CLK)
      if (!NRST)
      begin
         wr_q <= 1'b0;
         waddr_q <= '0;
         HRDATA <= '0;
         HREADYOUT <= 1'b1;
         pause_q <= 1'b0;
         clr_q <= 1'b0;
      end
      else if (CE)
      begin
         wr_q <= acc && HWRITE;
         waddr_q <= HADDR;
         HRDATA <= (acc && !HWRITE) ? rmux : 32'h0000_0000;
         clr_q <= wr_q && waddr_q == `LTG_OFF_CTRL && HWDATA[`LTG_CTRL_CLR];
         if (wr_q && waddr_q == `LTG_OFF_CTRL)
            pause_q <= HWDATA[`LTG_CTRL_PAUSE];
      end

   ////////////////////////////////////////////////////////////////////////////
   // housekeeping domain: reset and pma input each pass two flops first
   logic rst_s1;
   logic rst_s2;
   logic pma_s1;
   logic pma_s2;
   logic [DEB_LEN-1:0] deb_q;
   always_ff @(posedge INIT_CLK)
   begin
      rst_s1 <= NRST;
      rst_s2 <= rst_s1;
      pma_s1 <= PMA_INIT_IN;
      pma_s2 <= pma_s1;
   end

   // output moves only after DEB_LEN equal samples, so bounces never reach the core
   always_ff @(posedge INIT_CLK)
      if (!rst_s2)
      begin
         deb_q <= {DEB_LEN{`LTG_PMA_RST_VAL}};
         PMA_INIT_OUT <= `LTG_PMA_RST_VAL;
      end
      else
      begin
         deb_q <= {deb_q[DEB_LEN-2:0], pma_s2};
         if (&deb_q)
            PMA_INIT_OUT <= 1'b1;
         else if (~|deb_q)
            PMA_INIT_OUT <= 1'b0;
      end

   a_pma_debounce: assert property (@(posedge INIT_CLK) disable iff (!rst_s2)
      $changed(PMA_INIT_OUT) |-> $past(&deb_q) || $past(~|deb_q))
      else $error("pma output moved without stable samples");
endmodule

// [rtl/ltg_cfg.svh]
/*
 constants for the lfsr traffic generator/checker.
 assumes: included by the package and the design file by bare name.
*/
`ifndef LTG_CFG_SVH
`define LTG_CFG_SVH
// datapath and interface count
`define LTG_DW 64
`define LTG_NIF 4
`define LTG_IF_DATA 0
`define LTG_IF_UFC 1
`define LTG_IF_NFC 2
`define LTG_IF_USERK 3
// lfsr: x^16+x^14+x^13+x^11+1, seed is arbitrary but fixed
`define LTG_LW 16
`define LTG_LFSR_TAPS 16'hB400
`define LTG_LFSR_SEED 16'hD5A3
// checker counter
`define LTG_CNT_W 8
`define LTG_CNT_MAX 8'hFF
`define LTG_CNT_ONE 8'h01
// buffering and debounce
`define LTG_FIFO_DEPTH 16
`define LTG_DEB_LEN 4
`define LTG_PMA_RST_VAL 1'b1
// register map, byte offsets
`define LTG_OFF_CTRL 32'h0000_0000
`define LTG_OFF_STAT 32'h0000_0004
`define LTG_CTRL_PAUSE 0
`define LTG_CTRL_CLR 1
`define LTG_STAT_CHAN 8
`define LTG_STAT_HARD 9
`define LTG_STAT_SOFT 10
`define LTG_STAT_ERR 12
`define LTG_STAT_LANE 16
`endif

// [rtl/ltg_pkg.sv]
/*
 types and helpers shared by the traffic generator/checker.
 assumes: ltg_cfg.svh sits on the include path.
*/
`include "ltg_cfg.svh"
package ltg_pkg;
   // one stream beat towards or from the link core
   typedef struct packed
   {
      logic valid;
      logic [`LTG_DW-1:0] data;
   } ltg_beat_t;

   typedef logic [`LTG_LW-1:0] ltg_lfsr_t;

   // one fibonacci step, shifting towards the msb
   function automatic ltg_lfsr_t ltg_lfsr_next(input ltg_lfsr_t s);
      return {s[`LTG_LW-2:0], ^(s & `LTG_LFSR_TAPS)};
   endfunction

   // payload word: lfsr state replicated over the datapath
   function automatic logic [`LTG_DW-1:0] ltg_word(input ltg_lfsr_t s);
      return {(`LTG_DW / `LTG_LW){s}};
   endfunction
endpackage

// [testbench/ltg_link_model.sv]
/*
 link core stand-in: ready with optional random stalls, taken beats looped back.
 assumes: the bench seeds $urandom and drives chan, slow, junk and bad.
*/
module ltg_link_model
   import ltg_pkg::*;
(
   input logic clk,
   input logic nrst,
   input logic chan,
   input logic slow,
   input logic junk,
   input logic [3:0] bad,
   input ltg_beat_t [3:0] tx,
   output logic [3:0] ready,
   output ltg_beat_t [3:0] rx
);
   logic [3:0] go_q;

   // ready only while the channel is up; stalls make the sender hold its beat
   assign ready = go_q & {4{chan}};
   always_ff @(posedge clk)
   begin
      go_q <= slow ? 4'($urandom) : 4'hF;
   end

   ////////////////////////////////////////////////////////////////////////////
   // taken beats return next cycle; idle data inverts so stale words never match
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (!nrst)
            rx[i] <= '0;
         else if (tx[i].valid && ready[i])
            rx[i] <= '{1'b1, bad[i] ? ~tx[i].data : tx[i].data};
         else if (junk)
            rx[i] <= '{1'b1, {$urandom, $urandom}};
         else
            rx[i] <= '{1'b0, ~rx[i].data};
      end
   end
endmodule

// [testbench/ltg_top_bench.sv]
/*
 self-checking bench for ltg_top, link side looped back through a model.
 assumes: ltg_pkg is compiled first and ltg_cfg.svh is on the include path.
*/
`include "ltg_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
$display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module ltg_top_bench
   import ltg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK, INIT_CLK, HREADY, PMA_INIT_OUT, CHANNEL_UP, LANE_UP, HARD_ERR, SOFT_ERR, HREADYOUT, HRESP;
   logic NRST = 1'b0, CE = 1'b1, PMA_INIT_IN = 1'b0, CORE_CHANNEL_UP = 1'b0, CORE_LANE_UP = 1'b0;
   logic CORE_HARD_ERR = 1'b0, CORE_SOFT_ERR = 1'b0, slow = 1'b0, junk = 1'b0;
   logic HSEL = 1'b0, HWRITE = 1'b0;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic [3:0] TX_READY, RX_ERR, exp_err, st_q, bad = 4'h0;
   logic [7:0] MISMATCH_WORD_COUNT, exp_cnt = 8'h00;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
   ltg_beat_t [3:0] TX_BEAT, RX_BEAT;
   ltg_lfsr_t tx_s [4], rx_s [4];
   int bad_count = 0, n_checks = 0;
   ltg_beat_t [3:0] bare_tx;
   logic [3:0] bare_err;
   logic [7:0] bare_cnt;

   assign HREADY = HREADYOUT;
   ltg_top #(.DEB_LEN(2)) u_ltg_top (.CLK, .NRST, .CE, .INIT_CLK, .PMA_INIT_IN, .PMA_INIT_OUT,
      .CORE_CHANNEL_UP, .CORE_LANE_UP, .CORE_HARD_ERR, .CORE_SOFT_ERR, .TX_BEAT, .TX_READY, .RX_BEAT,
      .CHANNEL_UP, .LANE_UP, .HARD_ERR, .SOFT_ERR, .MISMATCH_WORD_COUNT, .RX_ERR, .HSEL, .HADDR,
      .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP);
   ltg_link_model u_ltg_link_model (.clk(CLK), .nrst(NRST), .chan(CORE_CHANNEL_UP), .slow, .junk,
      .bad, .tx(TX_BEAT), .ready(TX_READY), .rx(RX_BEAT));
   // neither direction built: streams and error outputs must stay quiet
   ltg_top #(.HAS_TX(1'b0), .HAS_RX(1'b0), .DEB_LEN(2)) u_ltg_top_bare (.CLK, .NRST, .CE, .INIT_CLK,
      .PMA_INIT_IN, .PMA_INIT_OUT(), .CORE_CHANNEL_UP, .CORE_LANE_UP, .CORE_HARD_ERR, .CORE_SOFT_ERR,
      .TX_BEAT(bare_tx), .TX_READY, .RX_BEAT, .CHANNEL_UP(), .LANE_UP(), .HARD_ERR(), .SOFT_ERR(),
      .MISMATCH_WORD_COUNT(bare_cnt), .RX_ERR(bare_err), .HSEL(1'b0), .HADDR, .HTRANS, .HWRITE, .HSIZE,
      .HWDATA, .HREADY(1'b1), .HRDATA(), .HREADYOUT(), .HRESP());

   ////////////////////////////////////////////////////////////////////////////
   // own reference lfsr, kept apart from the package helpers
   function automatic ltg_lfsr_t nx(input ltg_lfsr_t s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [63:0] wd(input ltg_lfsr_t s);
      return {4{s}};
   endfunction
   function automatic logic [3:0] vb();
      for (int i = 0; i < 4; i++)
         vb[i] = TX_BEAT[i].valid;
   endfunction

   // user clock
   initial
   begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   // housekeeping clock: free running, slower, phase unrelated
   initial
   begin
      INIT_CLK = 1'b0;
      #1.3;
      forever #10 INIT_CLK = ~INIT_CLK;
   end
   // random status levels from the core
   always @(posedge CLK)
      {CORE_LANE_UP, CORE_HARD_ERR, CORE_SOFT_ERR} <= 3'($urandom);

   ////////////////////////////////////////////////////////////////////////////
   // reference model: checks taken tx words, predicts error pulses and count
   always @(posedge CLK)
   begin
      st_q <= NRST ? {CORE_CHANNEL_UP, CORE_LANE_UP, CORE_HARD_ERR, CORE_SOFT_ERR} : 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         exp_err[i] <= 1'b0;
         if (!NRST || !CORE_CHANNEL_UP)
         begin
            tx_s[i] <= `LTG_LFSR_SEED;
            rx_s[i] <= `LTG_LFSR_SEED;
         end
         else
         begin
            if (TX_BEAT[i].valid && TX_READY[i])
            begin
               `CHK(TX_BEAT[i].data, wd(tx_s[i]))
               tx_s[i] <= nx(tx_s[i]);
            end
            if (RX_BEAT[i].valid)
            begin
               if (RX_BEAT[i].data !== wd(rx_s[i]))
               begin
                  exp_err[i] <= 1'b1;
                  if (i == 0 && exp_cnt != 8'hFF)
                     exp_cnt++;
               end
               rx_s[i] <= nx(rx_s[i]);
            end
         end
      end
      if (!NRST)
         exp_cnt = 8'h00;
   end
   // outputs looked at once settled
   always @(negedge CLK)
      if (NRST)
      begin
         `CHK(RX_ERR, exp_err)
         `CHK({CHANNEL_UP, LANE_UP, HARD_ERR, SOFT_ERR}, st_q)
         `CHK({bare_tx, bare_err, bare_cnt}, '0)
      end

   ////////////////////////////////////////////////////////////////////////////
   // one single ahb-lite transfer; waits for hready on both phases
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= a;
      HWRITE <= w;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   // drop the channel and let the streams go quiet
   task automatic down();
      CORE_CHANNEL_UP <= 1'b0;
      repeat (3) @(posedge CLK);
      #1;
      `CHK(vb(), 4'h0)
      `CHK(MISMATCH_WORD_COUNT, exp_cnt)
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge CLK);
      bad_count++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      void'($urandom(32'h77AD8895));
      repeat (12) @(posedge CLK);
      #1;
      `CHK(TX_BEAT[1], {1'b0, wd(`LTG_LFSR_SEED)})
      `CHK({MISMATCH_WORD_COUNT, RX_ERR, HREADYOUT, HRESP}, 14'h0002)
      @(posedge CLK);
      NRST <= 1'b1;
      slow <= 1'b1;
      CORE_CHANNEL_UP <= 1'b1;
      repeat (300) @(posedge CLK);
      repeat (40)
      begin
         bad <= 4'($urandom);
         @(posedge CLK);
      end
      bad <= 4'h0;
      slow <= 1'b0;
      repeat (200) @(posedge CLK);
      down();
      // garbage beats while the channel is down must be ignored
      junk <= 1'b1;
      bad <= 4'hF;
      repeat (20) @(posedge CLK);
      junk <= 1'b0;
      bad <= 4'h0;
      down();
      ahb(1'b0, `LTG_OFF_STAT, 32'h0);
      `CHK(rd[8:0], {1'b0, exp_cnt})
      ahb(1'b0, 32'h0000_0040, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b1, `LTG_OFF_CTRL, 32'h0000_0002);
      exp_cnt = 8'h00;
      repeat (2) @(posedge CLK);
      #1;
      `CHK(MISMATCH_WORD_COUNT, 8'h00)
      ahb(1'b1, `LTG_OFF_CTRL, 32'h0000_0001);
      ahb(1'b0, `LTG_OFF_CTRL, 32'h0);
      `CHK(rd[1:0], 2'h1)
      CORE_CHANNEL_UP <= 1'b1;
      repeat (30) @(posedge CLK);
      #1;
      `CHK(vb(), 4'h0)
      ahb(1'b1, `LTG_OFF_CTRL, 32'h0);
      // a long run of bad data words must pin the count at its top
      bad <= 4'h1;
      repeat (320) @(posedge CLK);
      bad <= 4'h0;
      down();
      `CHK(MISMATCH_WORD_COUNT, 8'hFF)
      CORE_CHANNEL_UP <= 1'b1;
      bad <= 4'hF;
      repeat (20) @(posedge CLK);
      NRST <= 1'b0;
      bad <= 4'h0;
      repeat (16) @(posedge CLK);
      #1;
      `CHK({MISMATCH_WORD_COUNT, RX_ERR, vb()}, 16'h0000)
      @(posedge CLK);
      NRST <= 1'b1;
      repeat (100) @(posedge CLK);
      down();
      PMA_INIT_IN <= 1'b1;
      repeat (40) @(posedge CLK);
      `CHK(PMA_INIT_OUT, 1'b1)
      PMA_INIT_IN <= 1'b0;
      repeat (40) @(posedge CLK);
      `CHK(PMA_INIT_OUT, 1'b0)
      PMA_INIT_IN <= 1'b1;
      @(posedge CLK);
      PMA_INIT_IN <= 1'b0;
      repeat (40) @(posedge CLK);
      `CHK(PMA_INIT_OUT, 1'b0)
      summarize();
   end
endmodule
